// File: design/pdc_params.svh
// Offsets, field positions, reset values and timing counts of the capability/control bank
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

`define PDC_ADDR_W          8
`define PDC_DATA_W          32
`define PDC_OFS_DEV_CAP     8'hC4
`define PDC_OFS_DEV_CTL     8'hC8

`define PDC_CAP_MPS_LSB     0
`define PDC_CAP_MPS_MSB     2
`define PDC_CAP_PHANTOM_LSB 3
`define PDC_CAP_PHANTOM_MSB 4
`define PDC_CAP_EXTTAG      5
`define PDC_CAP_L0S_LSB     6
`define PDC_CAP_L0S_MSB     8
`define PDC_CAP_L1_LSB      9
`define PDC_CAP_L1_MSB      11
`define PDC_CAP_RBER        15
`define PDC_CAP_SPLV_LSB    18
`define PDC_CAP_SPLV_MSB    25
`define PDC_CAP_SPLS_LSB    26
`define PDC_CAP_SPLS_MSB    27

`define PDC_CTL_ERR_LSB     0
`define PDC_CTL_ERR_MSB     3
`define PDC_CTL_RO_EN       4
`define PDC_CTL_MPS_LSB     5
`define PDC_CTL_MPS_MSB     7
`define PDC_CTL_AUXPM       10
`define PDC_STS_DET_LSB     16
`define PDC_STS_DET_MSB     19

`define PDC_MPS_STRAP_LO    3'h1
`define PDC_MPS_STRAP_HI    3'h2
`define PDC_MPS_ENC_MAX     3'h2
`define PDC_RST_PHANTOM     2'h0
`define PDC_RST_EXTTAG      1'h0
`define PDC_RST_L0S         3'h0
`define PDC_RST_L1          3'h0
`define PDC_RST_RBER        1'h1
`define PDC_RST_SPLV        8'h00
`define PDC_RST_SPLS        2'h0
`define PDC_RST_ERR_EN      4'h0
`define PDC_RST_MPS         3'h0
`define PDC_RST_AUXPM       1'h0
`define PDC_RST_DET         4'h0

`define PDC_SYNC_STAGES     2
`define PDC_STRAP_SETTLE    2'h3

`endif

// File: design/pdc_pkg.sv
// Types shared by the capability/control bank
`include "pdc_params.svh"
package pdc_pkg;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`PDC_ADDR_W-1:0] addr;
    logic [`PDC_DATA_W-1:0] wdata;
  } pdc_reg_req_t;

  typedef struct packed {
    logic                   valid;
    logic [`PDC_ADDR_W-1:0] addr;
    logic [`PDC_DATA_W-1:0] data;
  } pdc_hwinit_wr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pdc_spl_msg_t;

  typedef enum logic [2:0] {
    PDC_INIT_WAIT   = 3'b001,
    PDC_INIT_SAMPLE = 3'b010,
    PDC_INIT_DONE   = 3'b100
  } pdc_init_state_t;

endpackage : pdc_pkg

// File: design/pdc_regs.sv
// Device capability and device control/status configuration words of one switch port
//
// How it works
// - Payload supported resets from strap: 001b/010b
// - Payload up to 512B; strap/SMBus/EEPROM override
// - Phantom functions field always reads 00b
// - Extended tag supported bit reads zero
// - L0s acceptable latency reads 000b
// - L1 acceptable latency reads 000b
// - Role-based error bit resets one, loadable
// - Upstream slot power value from message
// - Upstream slot power scale from message
// - Control bit0 correctable error report enable
// - Control bit1 non-fatal error report enable
// - Control bit2 fatal error report enable
// - Control bit3 unsupported request report enable
// - Relaxed ordering enable reads zero always
// - Detected flags set regardless of enables
`include "pdc_params.svh"
module pdc_regs #(
  parameter bit UPSTREAM    = 1'b1, // Port is the upstream port
  parameter int SYNC_STAGES = `PDC_SYNC_STAGES
) (
  input  wire logic                   REF_CLK,               // Core clock, 40 MHz
  input  wire logic                   ARST_N,                // Fundamental reset, active low
  input  wire logic                   PAYLOAD_SIZE_STRAP,    // Payload strap pin, asynchronous
  input  pdc_pkg::pdc_reg_req_t       REG_REQ,               // Configuration register request
  output logic [`PDC_DATA_W-1:0]      REG_RDATA,             // Read data, cycle after read strobe
  input  pdc_pkg::pdc_hwinit_wr_t     HWINIT_WR,             // SMBus or EEPROM autoload write
  input  pdc_pkg::pdc_spl_msg_t       SPL_MSG,               // Received slot power limit message
  input  wire logic [3:0]             ERR_EVENT,             // Error detected pulses: cor, nf, fat, ur
  output logic [3:0]                  ERR_REPORT_EN,         // Reporting enables
  output logic [3:0]                  ERR_DETECTED,          // Detected error flags
  output logic [3:0]                  ERR_MSG,               // Error message request pulses
  output logic [2:0]                  MAX_PAYLOAD_SUPPORTED, // Supported payload encoding
  output logic [2:0]                  MAX_PAYLOAD_SIZE,      // Programmed payload encoding
  output logic                        INIT_DONE              // Strap sampling finished
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("pdc_regs needs at least two synchroniser stages");
  end

  logic strap_sync;

  pdc_sync #(
    .WIDTH  (1),
    .STAGES (SYNC_STAGES)
  ) u_strap_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .d      (PAYLOAD_SIZE_STRAP),
    .q      (strap_sync)
  );

  // Strap sampling after reset release
  pdc_pkg::pdc_init_state_t init_state_ff;
  pdc_pkg::pdc_init_state_t nxt_init_state;
  logic [1:0]               init_cnt_ff;
  logic [1:0]               nxt_init_cnt;
  logic                     init_done_ff;
  logic                     nxt_init_done;

  always_comb
  begin
    nxt_init_state = init_state_ff;
    nxt_init_cnt   = init_cnt_ff;
    nxt_init_done  = init_done_ff;
    case (init_state_ff)
      pdc_pkg::PDC_INIT_WAIT:
      begin
        if (init_cnt_ff == `PDC_STRAP_SETTLE)
        begin
          nxt_init_state = pdc_pkg::PDC_INIT_SAMPLE;
        end
        else
        begin
          nxt_init_cnt = init_cnt_ff + 2'h1;
        end
      end
      pdc_pkg::PDC_INIT_SAMPLE:
      begin
        nxt_init_state = pdc_pkg::PDC_INIT_DONE;
        nxt_init_done  = 1'b1;
      end
      pdc_pkg::PDC_INIT_DONE:
      begin
        nxt_init_state = pdc_pkg::PDC_INIT_DONE;
      end
      default:
      begin
        nxt_init_state = pdc_pkg::PDC_INIT_WAIT;
        nxt_init_cnt   = 2'h0;
        nxt_init_done  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      init_state_ff <= pdc_pkg::PDC_INIT_WAIT;
      init_cnt_ff   <= 2'h0;
      init_done_ff  <= 1'b0;
    end
    else
    begin
      init_state_ff <= nxt_init_state;
      init_cnt_ff   <= nxt_init_cnt;
      init_done_ff  <= nxt_init_done;
    end
  end

  // Hardware-initialised capability fields and captured slot power
  logic [2:0] mps_sup_ff;
  logic [2:0] nxt_mps_sup;
  logic       rber_ff;
  logic       nxt_rber;
  logic       hw_ovr_ff;
  logic       nxt_hw_ovr;
  logic [7:0] spl_val_ff;
  logic [7:0] nxt_spl_val;
  logic [1:0] spl_scale_ff;
  logic [1:0] nxt_spl_scale;
  logic [2:0] hw_mps;

  always_comb
  begin
    nxt_mps_sup   = mps_sup_ff;
    nxt_rber      = rber_ff;
    nxt_hw_ovr    = hw_ovr_ff;
    nxt_spl_val   = spl_val_ff;
    nxt_spl_scale = spl_scale_ff;
    hw_mps        = HWINIT_WR.data[`PDC_CAP_MPS_MSB:`PDC_CAP_MPS_LSB];
    if (init_state_ff == pdc_pkg::PDC_INIT_SAMPLE && !hw_ovr_ff)
    begin
      nxt_mps_sup = strap_sync ? `PDC_MPS_STRAP_HI : `PDC_MPS_STRAP_LO;
    end
    if (HWINIT_WR.valid && HWINIT_WR.addr == `PDC_OFS_DEV_CAP)
    begin
      nxt_mps_sup = (hw_mps > `PDC_MPS_ENC_MAX) ? `PDC_MPS_ENC_MAX : hw_mps;
      nxt_rber    = HWINIT_WR.data[`PDC_CAP_RBER];
      nxt_hw_ovr  = 1'b1;
    end
    if (UPSTREAM && SPL_MSG.valid)
    begin
      nxt_spl_val   = SPL_MSG.value;
      nxt_spl_scale = SPL_MSG.scale;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mps_sup_ff   <= `PDC_MPS_STRAP_LO;
      rber_ff      <= `PDC_RST_RBER;
      hw_ovr_ff    <= 1'b0;
      spl_val_ff   <= `PDC_RST_SPLV;
      spl_scale_ff <= `PDC_RST_SPLS;
    end
    else
    begin
      mps_sup_ff   <= nxt_mps_sup;
      rber_ff      <= nxt_rber;
      hw_ovr_ff    <= nxt_hw_ovr;
      spl_val_ff   <= nxt_spl_val;
      spl_scale_ff <= nxt_spl_scale;
    end
  end

  // Device control and status
  logic [3:0] err_en_ff;
  logic [3:0] nxt_err_en;
  logic [2:0] mps_ff;
  logic [2:0] nxt_mps;
  logic       auxpm_ff;
  logic       nxt_auxpm;
  logic [3:0] err_det_ff;
  logic [3:0] nxt_err_det;
  logic [3:0] err_msg_ff;
  logic [3:0] nxt_err_msg;
  logic [2:0] wr_mps;
  logic       ctl_wr;

  always_comb
  begin
    nxt_err_en  = err_en_ff;
    nxt_mps     = mps_ff;
    nxt_auxpm   = auxpm_ff;
    nxt_err_det = err_det_ff;
    ctl_wr      = REG_REQ.wr && REG_REQ.addr == `PDC_OFS_DEV_CTL;
    wr_mps      = REG_REQ.wdata[`PDC_CTL_MPS_MSB:`PDC_CTL_MPS_LSB];
    if (ctl_wr)
    begin
      nxt_err_en = REG_REQ.wdata[`PDC_CTL_ERR_MSB:`PDC_CTL_ERR_LSB];
      nxt_mps    = (wr_mps > nxt_mps_sup) ? nxt_mps_sup : wr_mps;
      nxt_auxpm  = REG_REQ.wdata[`PDC_CTL_AUXPM];
      nxt_err_det = err_det_ff & ~REG_REQ.wdata[`PDC_STS_DET_MSB:`PDC_STS_DET_LSB];
    end
    else if (mps_ff > nxt_mps_sup)
    begin
      nxt_mps = nxt_mps_sup;
    end
    nxt_err_det = nxt_err_det | ERR_EVENT;
    nxt_err_msg = ERR_EVENT & err_en_ff;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      err_en_ff  <= `PDC_RST_ERR_EN;
      mps_ff     <= `PDC_RST_MPS;
      auxpm_ff   <= `PDC_RST_AUXPM;
      err_det_ff <= `PDC_RST_DET;
      err_msg_ff <= 4'h0;
    end
    else
    begin
      err_en_ff  <= nxt_err_en;
      mps_ff     <= nxt_mps;
      auxpm_ff   <= nxt_auxpm;
      err_det_ff <= nxt_err_det;
      err_msg_ff <= nxt_err_msg;
    end
  end

  // Read path; writes to the capability word are dropped
  logic [`PDC_DATA_W-1:0] cap_word;
  logic [`PDC_DATA_W-1:0] ctl_word;
  logic [`PDC_DATA_W-1:0] rdata_ff;
  logic [`PDC_DATA_W-1:0] nxt_rdata;

  always_comb
  begin
    cap_word = '0;
    ctl_word = '0;
    cap_word[`PDC_CAP_MPS_MSB:`PDC_CAP_MPS_LSB]         = mps_sup_ff;
    cap_word[`PDC_CAP_PHANTOM_MSB:`PDC_CAP_PHANTOM_LSB] = `PDC_RST_PHANTOM;
    cap_word[`PDC_CAP_EXTTAG]                           = `PDC_RST_EXTTAG;
    cap_word[`PDC_CAP_L0S_MSB:`PDC_CAP_L0S_LSB]         = `PDC_RST_L0S;
    cap_word[`PDC_CAP_L1_MSB:`PDC_CAP_L1_LSB]           = `PDC_RST_L1;
    cap_word[`PDC_CAP_RBER]                             = rber_ff;
    cap_word[`PDC_CAP_SPLV_MSB:`PDC_CAP_SPLV_LSB]       = spl_val_ff;
    cap_word[`PDC_CAP_SPLS_MSB:`PDC_CAP_SPLS_LSB]       = spl_scale_ff;
    ctl_word[`PDC_CTL_ERR_MSB:`PDC_CTL_ERR_LSB]         = err_en_ff;
    ctl_word[`PDC_CTL_RO_EN]                            = 1'b0;
    ctl_word[`PDC_CTL_MPS_MSB:`PDC_CTL_MPS_LSB]         = mps_ff;
    ctl_word[`PDC_CTL_AUXPM]                            = auxpm_ff;
    ctl_word[`PDC_STS_DET_MSB:`PDC_STS_DET_LSB]         = err_det_ff;
    nxt_rdata = '0;
    if (REG_REQ.rd && REG_REQ.addr == `PDC_OFS_DEV_CAP)
    begin
      nxt_rdata = cap_word;
    end
    else if (REG_REQ.rd && REG_REQ.addr == `PDC_OFS_DEV_CTL)
    begin
      nxt_rdata = ctl_word;
    end
    else
    begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA             = rdata_ff;
  assign ERR_REPORT_EN         = err_en_ff;
  assign ERR_DETECTED          = err_det_ff;
  assign ERR_MSG               = err_msg_ff;
  assign MAX_PAYLOAD_SUPPORTED = mps_sup_ff;
  assign MAX_PAYLOAD_SIZE      = mps_ff;
  assign INIT_DONE             = init_done_ff;

endmodule : pdc_regs

// File: design/pdc_sync.sv
// Multi-stage synchroniser for asynchronous level inputs
module pdc_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             clk,    // Destination clock
  input  wire logic             arst_n, // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] d,      // Asynchronous input
  output logic      [WIDTH-1:0] q       // Synchronised output
);

  logic [WIDTH-1:0] stage_ff [STAGES];
  logic [WIDTH-1:0] nxt_stage [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("pdc_sync needs at least two stages");
  end

  always_comb
  begin
    nxt_stage[0] = d;
    for (int i = 1; i < STAGES; i++)
    begin
      nxt_stage[i] = stage_ff[i-1];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        stage_ff[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        stage_ff[i] <= nxt_stage[i];
      end
    end
  end

  assign q = stage_ff[STAGES-1];

endmodule : pdc_sync

// File: dv/pdc_regs_asserts.sv
// Port-level checks on the capability/control bank
`include "pdc_params.svh"
module pdc_regs_asserts #(
  parameter bit UPSTREAM = 1'b1 // Port is the upstream port
) (
  input  wire logic                   REF_CLK,               // Clock
  input  wire logic                   ARST_N,                // Reset
  input  pdc_pkg::pdc_reg_req_t       REG_REQ,               // Request
  input  wire logic [`PDC_DATA_W-1:0] REG_RDATA,             // Read data
  input  pdc_pkg::pdc_hwinit_wr_t     HWINIT_WR,             // Override
  input  pdc_pkg::pdc_spl_msg_t       SPL_MSG,               // Power msg
  input  wire logic [3:0]             ERR_EVENT,             // Events
  input  wire logic [3:0]             ERR_REPORT_EN,         // Enables
  input  wire logic [3:0]             ERR_DETECTED,          // Flags
  input  wire logic [3:0]             ERR_MSG,               // Messages
  input  wire logic [2:0]             MAX_PAYLOAD_SUPPORTED, // Supported
  input  wire logic                   INIT_DONE              // Init done
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_rd_cap;
    REG_REQ.rd && REG_REQ.addr == `PDC_OFS_DEV_CAP;
  endsequence
  sequence s_rd_ctl;
    REG_REQ.rd && REG_REQ.addr == `PDC_OFS_DEV_CTL;
  endsequence
  sequence s_spl;
    SPL_MSG.valid ##1 (!SPL_MSG.valid && REG_REQ.rd && REG_REQ.addr == `PDC_OFS_DEV_CAP);
  endsequence
  property p_cap_zero;
    s_rd_cap |=> REG_RDATA[11:3] == 9'h000;
  endproperty
  property p_cap_mps;
    s_rd_cap |=> REG_RDATA[31:28] == 4'h0 && REG_RDATA[2:0] == $past(MAX_PAYLOAD_SUPPORTED);
  endproperty
  property p_ro_en;
    s_rd_ctl |=> REG_RDATA[4] == 1'b0 && REG_RDATA[3:0] == $past(ERR_REPORT_EN);
  endproperty
  property p_en_wr;
    REG_REQ.wr && REG_REQ.addr == `PDC_OFS_DEV_CTL |=> ERR_REPORT_EN == $past(REG_REQ.wdata[3:0]);
  endproperty
  property p_msg;
    ERR_EVENT != 4'h0 |=> ERR_MSG == $past(ERR_EVENT & ERR_REPORT_EN);
  endproperty
  property p_no_msg;
    ERR_EVENT == 4'h0 |=> ERR_MSG == 4'h0;
  endproperty
  property p_det;
    ERR_EVENT != 4'h0 |=> (ERR_DETECTED & $past(ERR_EVENT)) == $past(ERR_EVENT);
  endproperty
  property p_spl;
    s_spl |=> !UPSTREAM || REG_RDATA[27:18] == {$past(SPL_MSG.scale, 2), $past(SPL_MSG.value, 2)};
  endproperty
  property p_spl_dn;
    s_rd_cap |=> UPSTREAM || REG_RDATA[27:18] == 10'h000;
  endproperty
  property p_c4_ro;
    INIT_DONE && REG_REQ.wr && REG_REQ.addr == `PDC_OFS_DEV_CAP && !HWINIT_WR.valid
      |=> $stable(MAX_PAYLOAD_SUPPORTED);
  endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("cap fixed fields not zero");
  a_cap_mps: assert property (p_cap_mps) else $error("cap payload field wrong");
  a_ro_en: assert property (p_ro_en) else $error("control low bits wrong");
  a_en_wr: assert property (p_en_wr) else $error("enable write lost");
  a_msg: assert property (p_msg) else $error("message not gated by enable");
  a_no_msg: assert property (p_no_msg) else $error("message without event");
  a_det: assert property (p_det) else $error("detected flag not set");
  a_spl: assert property (p_spl) else $error("slot power not captured");
  a_spl_dn: assert property (p_spl_dn) else $error("downstream slot power not zero");
  a_c4_ro: assert property (p_c4_ro) else $error("cap word took a write");
endmodule : pdc_regs_asserts

bind pdc_regs pdc_regs_asserts #(.UPSTREAM(UPSTREAM)) u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .HWINIT_WR(HWINIT_WR), .SPL_MSG(SPL_MSG), .ERR_EVENT(ERR_EVENT),
  .ERR_REPORT_EN(ERR_REPORT_EN), .ERR_DETECTED(ERR_DETECTED), .ERR_MSG(ERR_MSG),
  .MAX_PAYLOAD_SUPPORTED(MAX_PAYLOAD_SUPPORTED), .INIT_DONE(INIT_DONE));

// File: dv/tb_top.sv
// Self-checking bench for the capability/control bank
`include "pdc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    strap = 1'b0;
  pdc_pkg::pdc_reg_req_t   req = '0;
  pdc_pkg::pdc_hwinit_wr_t hw = '0;
  pdc_pkg::pdc_spl_msg_t   spl = '0;
  logic [3:0]              ev = 4'h0;
  logic [31:0]             rdata;
  logic [3:0]              en;
  logic [3:0]              det;
  logic [3:0]              msg;
  logic [2:0]              sup;
  logic                    done;
  logic                    rd_taken = 1'b0;
  logic                    rd_c4 = 1'b0;
  logic [31:0]             rdata_dn;
  logic [31:0]             exp_w;
  logic [2:0]              mps;
  logic [31:0]             exp_q[$];
  logic [31:0]             seed = 32'hFFA3C3F2;
  logic [31:0]             r;
  int                      n_mismatch = 0;
  int                      n_compared = 0;

  pdc_regs #(.UPSTREAM(1'b1), .SYNC_STAGES(2)) dut (.REF_CLK(clk), .ARST_N(arst_n), .PAYLOAD_SIZE_STRAP(strap),
    .REG_REQ(req), .REG_RDATA(rdata), .HWINIT_WR(hw), .SPL_MSG(spl), .ERR_EVENT(ev), .ERR_REPORT_EN(en),
    .ERR_DETECTED(det), .ERR_MSG(msg), .MAX_PAYLOAD_SUPPORTED(sup), .MAX_PAYLOAD_SIZE(mps), .INIT_DONE(done));

  // Downstream port: slot power fields stay zero
  pdc_regs #(.UPSTREAM(1'b0), .SYNC_STAGES(2)) dut_dn (.REF_CLK(clk), .ARST_N(arst_n), .PAYLOAD_SIZE_STRAP(strap),
    .REG_REQ(req), .REG_RDATA(rdata_dn), .HWINIT_WR(hw), .SPL_MSG(spl), .ERR_EVENT(ev), .ERR_REPORT_EN(),
    .ERR_DETECTED(), .ERR_MSG(), .MAX_PAYLOAD_SUPPORTED(), .MAX_PAYLOAD_SIZE(), .INIT_DONE());

  always #12.5 clk = ~clk;

  task automatic report_and_stop();
    n_mismatch += exp_q.size();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic bus(input logic w, input logic rr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{w, rr, a, d};
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask : rd

  task automatic do_reset(input logic s);
    arst_n <= 1'b0;
    strap  <= s;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 20 && done !== 1'b1; i++)
      @(posedge clk);
    if (done !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : do_reset

  // Read data stands in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_taken <= req.rd;
    rd_c4    <= req.rd && req.addr == `PDC_OFS_DEV_CAP;
  end
  always @(negedge clk)
  begin
    if (rd_taken)
    begin
      if (exp_q.size() == 0)
      begin
        n_mismatch++;
        $display("[FAIL] %0t read data with no expectation", $time);
      end
      else
      begin
        exp_w = exp_q.pop_front();
        chk(rdata, exp_w);
        chk(rdata_dn, rd_c4 ? (exp_w & 32'hF003_FFFF) : exp_w);
      end
    end
  end

  initial
  begin
    @(posedge clk);
    do_reset(1'b0);
    rd(`PDC_OFS_DEV_CAP, 32'h0000_8001);
    rd(`PDC_OFS_DEV_CTL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    bus(1'b1, 1'b0, `PDC_OFS_DEV_CAP, 32'hFFFF_FFFF);
    rd(`PDC_OFS_DEV_CAP, 32'h0000_8001);
    bus(1'b1, 1'b0, `PDC_OFS_DEV_CTL, 32'h0000_00FF);
    rd(`PDC_OFS_DEV_CTL, 32'h0000_002F);
    hw <= '{1'b1, `PDC_OFS_DEV_CTL, 32'h0000_0000};
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    hw <= '{1'b1, `PDC_OFS_DEV_CAP, 32'h0000_0007};
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    hw <= '0;
    rd(`PDC_OFS_DEV_CTL, 32'h0000_002F);
    rd(`PDC_OFS_DEV_CAP, 32'h0000_0002);
    @(negedge clk);
    chk(sup, 3'h2);
    bus(1'b1, 1'b0, `PDC_OFS_DEV_CTL, 32'h000F_04E0);
    rd(`PDC_OFS_DEV_CTL, 32'h0000_0440);
    @(negedge clk);
    chk(mps, 3'h2);
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      bus(1'b1, 1'b0, `PDC_OFS_DEV_CTL, {12'h000, 4'hF, 12'h000, r[3:0]});
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      ev <= r[7:4];
      @(posedge clk);
      ev <= 4'h0;
      @(negedge clk);
      chk(msg, r[7:4] & r[3:0]);
      chk(det, r[7:4]);
      chk(en, r[3:0]);
      rd(`PDC_OFS_DEV_CTL, {12'h000, r[7:4], 12'h000, r[3:0]});
    end
    r = rnd();
    spl <= '{1'b1, r[7:0], r[9:8]};
    rd(`PDC_OFS_DEV_CAP, {4'h0, r[9:8], r[7:0], 3'h0, 12'h000, 3'h2});
    spl <= '0;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (2) @(posedge clk);
    do_reset(1'b1);
    rd(`PDC_OFS_DEV_CAP, 32'h0000_8002);
    rd(`PDC_OFS_DEV_CTL, 32'h0000_0000);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_top
